// >>> rtl/iwdec_defs.svh
// Constants for the instruction word decoder: field positions, format codes and timing
`ifndef IWDEC_DEFS_SVH
`define IWDEC_DEFS_SVH

`define IWDEC_WORD_W        14
`define IWDEC_FILE_W        7
`define IWDEC_BIT_W         3
`define IWDEC_LIT8_W        8
`define IWDEC_LIT11_W       11
`define IWDEC_DATA_W        8
`define IWDEC_OPC6_HI       13
`define IWDEC_OPC6_LO       8
`define IWDEC_OPC4_LO       10
`define IWDEC_OPC3_LO       11
`define IWDEC_DEST_BIT      7
`define IWDEC_BIDX_HI       9
`define IWDEC_BIDX_LO       7
`define IWDEC_FILE_HI       6
`define IWDEC_LIT8_HI       7
`define IWDEC_LIT11_HI      10
`define IWDEC_TOP2_HI       13
`define IWDEC_TOP2_LO       12
`define IWDEC_TOP2_BYTE     2'h0
`define IWDEC_TOP2_BIT      2'h1
`define IWDEC_TOP2_JUMP     2'h2
`define IWDEC_TOP2_LIT      2'h3
`define IWDEC_FILE_MIN      7'h00
`define IWDEC_FILE_MAX      7'h7F
`define IWDEC_CALL_OPC      3'h4
`define IWDEC_JUMP_OPC      3'h5
`define IWDEC_QPHASES       4
`define IWDEC_Q_LAST        2'h3
`define IWDEC_Q_FIRST       2'h0
`define IWDEC_OSC_NS        5

`endif

// >>> rtl/iwdec_pkg.sv
// Types shared by the instruction word decoder
package iwdec_pkg;

    typedef enum logic [1:0] {
        IWDEC_FMT_BYTE = 2'b00,
        IWDEC_FMT_BIT  = 2'b01,
        IWDEC_FMT_LIT  = 2'b10,
        IWDEC_FMT_JUMP = 2'b11
    } iwdec_fmt_t;

    typedef struct packed {
        logic        valid;
        iwdec_fmt_t  fmt;
        logic [5:0]  opcode;
        logic        dest_file;
        logic        dest_work;
        logic [2:0]  bit_index;
        logic [7:0]  bit_mask;
        logic [6:0]  file_addr;
        logic [7:0]  literal8;
        logic [10:0] literal11;
        logic        is_call;
        logic        is_jump;
        logic        bubble;
    } iwdec_dec_t;

endpackage : iwdec_pkg

// >>> rtl/iwdec_qphase.sv
// Four-phase instruction cycle sequencer
`timescale 1ns/10ps
`include "iwdec_defs.svh"

module iwdec_qphase (
    input  wire logic       clk,
    input  wire logic       rst,
    output logic [1:0]      q_phase,
    output logic            cycle_start,
    output logic            cycle_end
);
    logic [1:0] q_reg;
    logic [1:0] q_next;

    always_comb begin
        q_next = q_reg + 2'h1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_reg <= `IWDEC_Q_FIRST;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_phase     = q_reg;
    assign cycle_start = (q_reg == `IWDEC_Q_FIRST);
    assign cycle_end   = (q_reg == `IWDEC_Q_LAST);
endmodule : iwdec_qphase

// >>> rtl/iwdec_top.sv
// Instruction word decoder: format split, operand fields and cycle timing
//
// Function
// - Each instruction is one 14-bit word: opcode plus operand fields.
// - Byte format: opcode 13:8, destination bit 7, file address 6:0.
// - Destination zero writes working register; one writes the file register.
// - File address spans 0x00 through 0x7F.
// - Bit format: opcode 13:10, bit index 9:7, file address 6:0.
// - Bit index picks one bit of the 8-bit addressed register.
// - Literal format: opcode 13:8, 8-bit literal 7:0.
// - Call and jump: opcode 13:11, 11-bit target 10:0.
// - One cycle normally; taken test or PC change adds a no-operation cycle.
// - One instruction cycle spans four clock periods.
// - Don't-care opcode bits are passed through unmasked into the decoded opcode.
`timescale 1ns/10ps
`include "iwdec_defs.svh"

module iwdec_top (
    input  wire logic                        CLOCK,
    input  wire logic                        RST,
    input  wire logic [`IWDEC_WORD_W-1:0]    INSTR_WORD,
    input  wire logic                        INSTR_VALID,
    input  wire logic                        BRANCH_TAKEN,
    output iwdec_pkg::iwdec_dec_t            DECODED,
    output logic [1:0]                       Q_PHASE,
    output logic                             CYCLE_END,
    output logic                             FETCH_READY,
    output logic                             NOP_CYCLE
);
    import iwdec_pkg::*;

    // ------------------------------------------------------------
    // Instruction cycle phases
    // ------------------------------------------------------------
    logic [1:0] q_phase;
    logic       cycle_start;
    logic       cycle_end;

    iwdec_qphase u_qphase (
        .clk         (CLOCK),
        .rst         (RST),
        .q_phase     (q_phase),
        .cycle_start (cycle_start),
        .cycle_end   (cycle_end)
    );

    // ------------------------------------------------------------
    // Format classification and field extraction
    // ------------------------------------------------------------
    iwdec_dec_t dec_comb;
    iwdec_fmt_t fmt_comb;
    logic [1:0] top2;
    logic [2:0] opc3;

    always_comb begin
        top2 = INSTR_WORD[`IWDEC_TOP2_HI:`IWDEC_TOP2_LO];
        opc3 = INSTR_WORD[`IWDEC_OPC6_HI:`IWDEC_OPC3_LO];
        // Format first, fields after: decode never depends on operand bits
        case (top2)
            `IWDEC_TOP2_BYTE: fmt_comb = IWDEC_FMT_BYTE;
            `IWDEC_TOP2_BIT:  fmt_comb = IWDEC_FMT_BIT;
            `IWDEC_TOP2_JUMP: fmt_comb = IWDEC_FMT_JUMP;
            `IWDEC_TOP2_LIT:  fmt_comb = IWDEC_FMT_LIT;
            default:          fmt_comb = IWDEC_FMT_BYTE;
        endcase

        dec_comb           = '0;
        dec_comb.valid     = INSTR_VALID;
        dec_comb.fmt       = fmt_comb;
        case (fmt_comb)
            IWDEC_FMT_BYTE: begin
                dec_comb.opcode    = INSTR_WORD[`IWDEC_OPC6_HI:`IWDEC_OPC6_LO];
                dec_comb.file_addr = INSTR_WORD[`IWDEC_FILE_HI:0];
                dec_comb.dest_file = INSTR_WORD[`IWDEC_DEST_BIT];
                dec_comb.dest_work = ~INSTR_WORD[`IWDEC_DEST_BIT];
            end
            IWDEC_FMT_BIT: begin
                dec_comb.opcode    = {2'h0, INSTR_WORD[`IWDEC_OPC6_HI:`IWDEC_OPC4_LO]};
                dec_comb.file_addr = INSTR_WORD[`IWDEC_FILE_HI:0];
                dec_comb.bit_index = INSTR_WORD[`IWDEC_BIDX_HI:`IWDEC_BIDX_LO];
                dec_comb.bit_mask  = 8'h01 << INSTR_WORD[`IWDEC_BIDX_HI:`IWDEC_BIDX_LO];
            end
            IWDEC_FMT_LIT: begin
                // Literal opcodes carry don't-care low bits; downstream masks them
                dec_comb.opcode   = INSTR_WORD[`IWDEC_OPC6_HI:`IWDEC_OPC6_LO];
                dec_comb.literal8 = INSTR_WORD[`IWDEC_LIT8_HI:0];
            end
            IWDEC_FMT_JUMP: begin
                dec_comb.opcode    = {3'h0, opc3};
                dec_comb.literal11 = INSTR_WORD[`IWDEC_LIT11_HI:0];
                // Bit 11 alone separates call from jump; it is never a don't-care
                dec_comb.is_call   = (opc3 == `IWDEC_CALL_OPC);
                dec_comb.is_jump   = (opc3 == `IWDEC_JUMP_OPC);
            end
            default: begin
                dec_comb.opcode = '0;
            end
        endcase
        // Jump format ignores lower fields, so stray bits cannot alter it
        dec_comb.bubble = INSTR_VALID && (fmt_comb == IWDEC_FMT_JUMP);
    end

    // ------------------------------------------------------------
    // Latch decode at cycle start; insert no-operation cycle
    // ------------------------------------------------------------
    iwdec_dec_t dec_reg;
    iwdec_dec_t dec_next;
    logic       nop_reg;
    logic       nop_next;
    logic       pend_reg;
    logic       pend_next;

    always_comb begin
        dec_next  = dec_reg;
        nop_next  = nop_reg;
        pend_next = pend_reg;
        // Taken test or jump marks the following cycle as a bubble
        if (cycle_end && dec_reg.valid && (BRANCH_TAKEN || dec_reg.bubble)) begin
            pend_next = 1'b1;
        end
        if (cycle_start) begin
            if (pend_reg) begin
                dec_next  = '0;
                nop_next  = 1'b1;
                pend_next = 1'b0;
            end else begin
                dec_next = dec_comb;
                nop_next = 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            dec_reg  <= '0;
            nop_reg  <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            dec_reg  <= dec_next;
            nop_reg  <= nop_next;
            pend_reg <= pend_next;
        end
    end

    assign DECODED     = dec_reg;
    assign Q_PHASE     = q_phase;
    assign CYCLE_END   = cycle_end;
    // Word is sampled only in phase zero and never during a bubble
    assign FETCH_READY = cycle_start && !pend_reg;
    assign NOP_CYCLE   = nop_reg;
endmodule : iwdec_top

// >>> testbench/iwdec_chk_asserts.sv
// Port-level checker for the instruction word decoder
`timescale 1ns/10ps
module iwdec_chk (
    input wire logic             CLOCK,
    input wire logic             RST,
    input wire logic [13:0]      INSTR_WORD,
    input wire logic             INSTR_VALID,
    input wire logic             BRANCH_TAKEN,
    input iwdec_pkg::iwdec_dec_t DECODED,
    input wire logic [1:0]       Q_PHASE,
    input wire logic             CYCLE_END,
    input wire logic             FETCH_READY,
    input wire logic             NOP_CYCLE
);
    import iwdec_pkg::*;
    logic        take;
    logic [13:0] w;
    iwdec_dec_t  d;
    assign take = FETCH_READY && INSTR_VALID && Q_PHASE == 2'h0;
    assign w = INSTR_WORD;
    assign d = DECODED;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    // ----------
    // Properties
    // ----------
    property p_fmt; take |=> d.fmt == {$past(w[13]), ^$past(w[13:12])}; endproperty
    a_fmt: assert property (p_fmt) else $error("format wrong");
    property p_file; take && !w[13] |=> d.file_addr == $past(w[6:0]); endproperty
    a_file: assert property (p_file) else $error("file address wrong");
    property p_dest; take && w[13:12] == 2'h0 |=>
        d.dest_file == $past(w[7]) && d.dest_work != $past(w[7]); endproperty
    a_dest: assert property (p_dest) else $error("destination wrong");
    property p_bit; take && w[13:12] == 2'h1 |=>
        d.bit_mask == 8'h01 << $past(w[9:7]) && d.bit_index == $past(w[9:7]); endproperty
    a_bit: assert property (p_bit) else $error("bit select wrong");
    property p_lit; take && w[13:12] == 2'h3 |=>
        d.literal8 == $past(w[7:0]) && d.opcode == $past(w[13:8]); endproperty
    a_lit: assert property (p_lit) else $error("literal wrong");
    property p_jmp; take && w[13:12] == 2'h2 |=>
        d.literal11 == $past(w[10:0]) && d.is_call != $past(w[11])
        && d.is_jump == $past(w[11]); endproperty
    a_jmp: assert property (p_jmp) else $error("target wrong");
    property p_q; Q_PHASE == 2'h0 |=> Q_PHASE == 2'h1 ##1 Q_PHASE == 2'h2
        ##1 Q_PHASE == 2'h3 && CYCLE_END ##1 Q_PHASE == 2'h0; endproperty
    a_q: assert property (p_q) else $error("phase sequence wrong");
    // Only a valid instruction can ask for the extra cycle
    property p_nop; CYCLE_END && d.valid && (BRANCH_TAKEN || d.fmt == IWDEC_FMT_JUMP) |=>
        !FETCH_READY ##1 NOP_CYCLE [*4]; endproperty
    a_nop: assert property (p_nop) else $error("no-operation cycle missing");
    c_jump: cover property (take && w[13:12] == 2'h2);
    c_taken: cover property (CYCLE_END && BRANCH_TAKEN);
    c_nop: cover property (NOP_CYCLE);
endmodule : iwdec_chk

// >>> testbench/tb.sv
// Self-checking bench for the instruction word decoder
`timescale 1ns/10ps
module tb;
    import iwdec_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [13:0] instr_word = 14'h0000;
    logic        instr_valid = 1'b0;
    logic        branch_taken = 1'b0;
    iwdec_dec_t  decoded;
    logic [1:0]  q_phase;
    logic        cycle_end;
    logic        fetch_ready;
    logic        nop_cycle;
    int          err_count = 0;
    int          checks = 0;
    int          cycles = 0;
    initial forever #2.5 clock = ~clock;
    iwdec_top u_dut (.CLOCK(clock), .RST(rst), .INSTR_WORD(instr_word),
        .INSTR_VALID(instr_valid), .BRANCH_TAKEN(branch_taken), .DECODED(decoded),
        .Q_PHASE(q_phase), .CYCLE_END(cycle_end), .FETCH_READY(fetch_ready),
        .NOP_CYCLE(nop_cycle));
    // -----
    // Tasks
    // -----
    task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic wait_q(input logic [1:0] q);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (q_phase !== q && n < 16);
    endtask : wait_q
    task automatic run(input logic [13:0] w, input logic bt);
        iwdec_dec_t e;
        logic [1:0] t;
        logic       bub;
        t = w[13:12];
        bub = bt || (t == 2'h2);
        e = '0;
        e.valid = 1'b1;
        e.fmt = iwdec_fmt_t'({w[13], ^t});
        e.opcode = w[13] ? (w[12] ? w[13:8] : {3'h0, w[13:11]})
                         : (w[12] ? {2'h0, w[13:10]} : w[13:8]);
        e.file_addr = w[13] ? 7'h00 : w[6:0];
        e.dest_file = (t == 2'h0) & w[7];
        e.dest_work = (t == 2'h0) & !w[7];
        e.bit_index = (t == 2'h1) ? w[9:7] : 3'h0;
        e.bit_mask = (t == 2'h1) ? 8'h01 << w[9:7] : 8'h00;
        e.literal8 = (t == 2'h3) ? w[7:0] : 8'h00;
        e.literal11 = (t == 2'h2) ? w[10:0] : 11'h000;
        e.is_call = (w[13:11] == 3'h4);
        e.is_jump = (w[13:11] == 3'h5);
        e.bubble = (t == 2'h2);
        wait_q(2'h3);
        @(posedge clock);
        instr_word <= w;
        instr_valid <= 1'b1;
        branch_taken <= bt;
        wait_q(2'h1);
        check("decoded", decoded, e);
        wait_q(2'h3);
        check("cycle_end", cycle_end, 1'b1);
        @(posedge clock);
        // Word is withdrawn once taken, so the next phase zero sees no valid word
        branch_taken <= 1'b0;
        instr_valid <= 1'b0;
        #1;
        check("fetch_ready", fetch_ready, !bub);
        @(posedge clock);
        #1;
        e.valid = 1'b0;
        if (bub) begin
            e = '0;
        end
        check("nop_cycle", nop_cycle, bub);
        check("decoded next", decoded, e);
    endtask : run
    task automatic t_reset;
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        check("reset state", {q_phase, fetch_ready, nop_cycle, decoded}, 64'h0000_0000_0000_0002 << 51);
        $display("test reset done");
    endtask : t_reset
    task automatic t_words;
        run(14'h0780, 1'b0);
        run(14'h077F, 1'b0);
        for (int b = 0; b < 8; b++) begin
            run({4'h5, b[2:0], 7'h3A}, 1'b0);
        end
        run(14'h1A05, 1'b1);
        run(14'h30A5, 1'b0);
        run(14'h33A5, 1'b0);
        run(14'h2123, 1'b0);
        run(14'h2FFF, 1'b0);
        run(14'h0780, 1'b0);
        $display("test words done");
    endtask : t_words
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        t_reset();
        t_words();
        t_reset();
        wrap_up();
    end
endmodule : tb
bind iwdec_top iwdec_chk u_chk (.CLOCK(CLOCK), .RST(RST), .INSTR_WORD(INSTR_WORD),
    .INSTR_VALID(INSTR_VALID), .BRANCH_TAKEN(BRANCH_TAKEN), .DECODED(DECODED),
    .Q_PHASE(Q_PHASE), .CYCLE_END(CYCLE_END), .FETCH_READY(FETCH_READY),
    .NOP_CYCLE(NOP_CYCLE));
